// [adcr_core_model.sv]
// converter core model: delivers one result and comparator levels per start
`timescale 1ns/1ns
`include "adcr_regs.svh"
module adcr_core_model
  import adcr_pkg::*;
(
  // clock and start request
  input wire logic core_clk_i,
  input wire logic go_i,
  input wire logic [`ADCR_RES_W-1:0] value_i,
  input wire logic [`ADCR_LIM_W-1:0] flags_i,
  // towards the register block
  output logic conv_done_o,
  output logic [`ADCR_RES_W-1:0] conv_result_o,
  output logic [`ADCR_LIM_W-1:0] limit_raw_o
);
  logic [2:0] wait_cnt; // cycles left until the result lands
  logic [`ADCR_RES_W-1:0] held; // result of the running conversion
  initial
  begin
    conv_done_o = 1'b0;
    conv_result_o = '1;
    limit_raw_o = '0;
    wait_cnt = 3'h0;
    held = '0;
  end
  // levels change at start, done comes late enough to pass the synchroniser
  // the result bus carries the inverse outside the done cycle, never stale data
  // plain always, since the initial block also gives these their power-up values
  always @(posedge core_clk_i)
  begin
    conv_done_o <= (wait_cnt == 3'h1);
    conv_result_o <= (wait_cnt == 3'h1) ? held : ~held;
    if (go_i)
    begin
      held <= value_i;
      limit_raw_o <= flags_i;
      wait_cnt <= 3'h4;
    end
    else if (wait_cnt != 3'h0)
      wait_cnt <= wait_cnt - 3'h1;
  end
endmodule

// [adcr_pkg.sv]
// types shared by the converter register block
package adcr_pkg;
  `include "adcr_regs.svh"

  // one register access from the serial transaction engine
  typedef struct packed {
    logic wr;                          // write strobe, one cycle
    logic sample;                      // read sample strobe, one cycle
    logic [`ADCR_ADDR_W-1:0] addr;     // register address
    logic [`ADCR_DATA_W-1:0] wdata;    // write data
  } adcr_req_t;

  // converter control register contents
  typedef struct packed {
    logic output_format_select;        // output_format_select
    logic [1:0] rbm;  // readback_mode_field
    logic [1:0] cfd;  // clock_divide_field
  } adcr_ctrl_t;
endpackage

// [adcr_regs.sv]
// converter result, limit flag and control registers with the conversion clock divider
`timescale 1ns/1ns
// How it works
// - result registers at 0 and 1, read only
// - low byte: result 5..0, zero, overrange
// - high byte holds result bits 13..6
// - overrange set on limit violation, else clear
// - serial bit order follows the lsb-first select
// - limit flags at address 2, top bits zero
// - flag order: pos in, pos out hi/lo, neg
// - format bit 5: 0 twos complement, 1 binary
// - readback mode field selects automatic return
// - divide field gives divide by 1, 2, 4, 8
// - divided clock feeds converter, at most 2.5 MHz; codes 0 and 1 still give 10 and 5 MHz and only raise the over limit output
// - reset clears every register bit to zero
// - read returns contents at the sample strobe
`include "adcr_regs.svh"
module adcr_regs
  import adcr_pkg::*;
#(
  parameter int CONVERTER_INPUT_CLOCK_HZ = `ADCR_CONVERTER_INPUT_CLOCK_HZ,
  parameter int DIVIDED_CONVERSION_CLOCK_MAX_HZ = `ADCR_DIVIDED_CONVERSION_CLOCK_MAX_HZ
)
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register access from the serial engine
  input wire adcr_req_t req_i,
  input wire logic lsb_first_i,
  input wire logic shift_i,
  // converter core
  input wire logic conv_done_i,
  input wire logic [`ADCR_RES_W-1:0] conv_result_i,
  input wire logic [`ADCR_LIM_W-1:0] limit_raw_i,
  // read data and serial bit
  output logic [`ADCR_DATA_W-1:0] rdata_o,
  output logic sdo_o,
  // control outputs
  output logic output_format_select_o,
  output logic [1:0] readback_mode_field_o,
  output logic [1:0] clock_divide_field_o,
  output logic divided_conversion_clock_en_o,
  output logic divided_conversion_clock_over_limit_o
);

  // reverse the bit order of one byte
  function automatic logic [`ADCR_DATA_W-1:0] rev_byte(input logic [`ADCR_DATA_W-1:0] b);
    logic [`ADCR_DATA_W-1:0] r;
    r = `ADCR_BYTE_ZERO;
    for (int i = 0; i < `ADCR_DATA_W; i++)
    begin
      r[i] = b[`ADCR_DATA_W-1-i];
    end
    return r;
  endfunction

  // divisor for a divide code, one bit wider than the divider count
  function automatic logic [`ADCR_DIV_CNT_W:0] div_of(input logic [1:0] code);
    return (`ADCR_DIV_CNT_W+1)'(1) << code;
  endfunction

  // control register state
  adcr_ctrl_t ctrl;
  // stored conversion result, twos complement
  logic [`ADCR_RES_W-1:0] result;
  // overrange_flag of the stored result
  logic overrange_flag;
  // limit comparator synchroniser, first and second stage
  logic [`ADCR_LIM_W-1:0] lim_meta;
  logic [`ADCR_LIM_W-1:0] lim_sync;
  // serial shift register
  logic [`ADCR_DATA_W-1:0] shreg;
  // divider counter
  logic [`ADCR_DIV_CNT_W-1:0] div_cnt;

  // named flag wires, bit 0 to bit 5
  wire pos_input_high_flag = lim_sync[0];
  wire pos_output_high_flag = lim_sync[1];
  wire pos_output_low_flag = lim_sync[2];
  wire neg_input_high_flag = lim_sync[3];
  wire neg_output_high_flag = lim_sync[4];
  wire neg_output_low_flag = lim_sync[5];
  wire [`ADCR_LIM_W-1:0] limit_flags = {neg_output_low_flag, neg_output_high_flag,
    neg_input_high_flag, pos_output_low_flag, pos_output_high_flag, pos_input_high_flag};

  // decode of accesses
  wire ctrl_wr = req_i.wr && (req_i.addr == `ADCR_ADDR_CTRL);
  wire sel_low = req_i.addr == `ADCR_ADDR_RES_LOW;
  wire sel_high = req_i.addr == `ADCR_ADDR_RES_HIGH;
  wire sel_lim = req_i.addr == `ADCR_ADDR_LIMITS;
  wire sel_ctrl = req_i.addr == `ADCR_ADDR_CTRL;

  // result as presented: offset binary in binary mode
  wire [`ADCR_RES_W-1:0] fmt_res = ctrl.output_format_select ?
    {~result[`ADCR_RES_W-1], result[`ADCR_RES_W-2:0]} : result;

  // byte images of each register
  wire [`ADCR_DATA_W-1:0] low_byte = {fmt_res[`ADCR_RES_LOW_TOP:0], 1'b0, overrange_flag};
  wire [`ADCR_DATA_W-1:0] high_byte = fmt_res[`ADCR_RES_W-1:`ADCR_RES_HIGH_BOT];
  wire [`ADCR_DATA_W-1:0] lim_byte = {2'b00, limit_flags};
  wire [`ADCR_DATA_W-1:0] ctrl_byte = {2'b00, ctrl.output_format_select, 1'b0, ctrl.rbm, ctrl.cfd};

  // read multiplexer, unmapped addresses read zero
  wire [`ADCR_DATA_W-1:0] rd_mux = sel_low ? low_byte :
    sel_high ? high_byte :
    sel_lim ? lim_byte :
    sel_ctrl ? ctrl_byte : `ADCR_BYTE_ZERO;

  // byte loaded into the shifter in transmit order
  wire [`ADCR_DATA_W-1:0] tx_byte = lsb_first_i ? rev_byte(rd_mux) : rd_mux;

  // divider wrap point; a greater-or-equal test lets a smaller code that takes effect
  // at once restart the count instead of running on to the old end point
  // divider wrap point
  wire [`ADCR_DIV_CNT_W:0] divisor = div_of(ctrl.cfd);
  wire div_wrap = ({1'b0, div_cnt} + (`ADCR_DIV_CNT_W+1)'(1)) >= divisor;
  wire [`ADCR_DIV_CNT_W-1:0] next_div_cnt = div_wrap ? `ADCR_DIV_CNT_ZERO :
    div_cnt + `ADCR_DIV_CNT_ONE;

  // divided clock rate above the limit for the current code
  wire over_limit = (CONVERTER_INPUT_CLOCK_HZ / int'(divisor)) > DIVIDED_CONVERSION_CLOCK_MAX_HZ;

  // control register; reserved positions are not stored and read zero
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      ctrl <= adcr_ctrl_t'(0);
    else if (ctrl_wr)
      ctrl <= {req_i.wdata[`ADCR_CTRL_BIN_BIT],
        req_i.wdata[`ADCR_CTRL_RBM_HI:`ADCR_CTRL_RBM_LO],
        req_i.wdata[`ADCR_CTRL_CFD_HI:`ADCR_CTRL_CFD_LO]};
  end

  // limit comparator synchroniser
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      lim_meta <= `ADCR_LIM_RESET;
      lim_sync <= `ADCR_LIM_RESET;
    end
    else
    begin
      lim_meta <= limit_raw_i;
      lim_sync <= lim_meta;
    end
  end

  // result capture; only the converter updates it, never a write
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      result <= `ADCR_RES_RESET;
      overrange_flag <= 1'b0;
    end
    else if (conv_done_i)
    begin
      result <= conv_result_i;
      overrange_flag <= |lim_sync;
    end
  end

  // read sample and serial shifter
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= `ADCR_BYTE_ZERO;
      shreg <= `ADCR_BYTE_ZERO;
    end
    else if (req_i.sample)
    begin
      rdata_o <= rd_mux;
      shreg <= tx_byte;
    end
    else if (shift_i)
      shreg <= {shreg[`ADCR_DATA_W-2:0], 1'b0};
  end

  // serial bit is the top of the shifter
  assign sdo_o = shreg[`ADCR_DATA_W-1];

  // conversion clock divider, one enable pulse per divided period
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      div_cnt <= `ADCR_DIV_CNT_ZERO;
      divided_conversion_clock_en_o <= 1'b0;
      divided_conversion_clock_over_limit_o <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      divided_conversion_clock_en_o <= div_wrap;
      divided_conversion_clock_over_limit_o <= over_limit;
    end
  end

  // control fields straight from the register
  assign output_format_select_o = ctrl.output_format_select;
  assign readback_mode_field_o = ctrl.rbm;
  assign clock_divide_field_o = ctrl.cfd;

  // writes never disturb the stored result
  chk_result_read_only: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.wr && !conv_done_i) |=> $stable(result))
    else $error("result changed by a write");

  // low byte layout at the sample
  chk_low_byte_layout: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.sample && sel_low) |=> (rdata_o[1] == 1'b0) &&
    (rdata_o[0] == $past(overrange_flag)) && (rdata_o[7:2] == $past(fmt_res[5:0])))
    else $error("low result byte layout wrong");

  // high byte layout at the sample
  chk_high_byte_layout: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.sample && sel_high) |=> rdata_o == $past(fmt_res[13:6]))
    else $error("high result byte layout wrong");

  // overrange follows the comparators at capture
  chk_overrange_capture: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    conv_done_i |=> overrange_flag == (|$past(lim_sync)))
    else $error("overrange flag mismatch");

  // first serial bit follows the bit order
  chk_serial_order: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    req_i.sample |=> sdo_o == ($past(lsb_first_i) ? rdata_o[0] : rdata_o[7]))
    else $error("first serial bit wrong");

  // limit flag register reads the comparators, top bits zero
  chk_limit_flags: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.sample && sel_lim) |=> rdata_o == {2'b00, $past(lim_sync)})
    else $error("limit flag register wrong");

  // binary mode inverts only the top result bit, seen on the high byte
  chk_binary_format: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.sample && sel_high && output_format_select_o) |=>
    (rdata_o[7] == !$past(result[13])) && (rdata_o[6:0] == $past(result[12:6])))
    else $error("binary format wrong");

  // twos complement mode passes the stored result unchanged
  chk_twos_format: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.sample && sel_high && !output_format_select_o) |=>
    rdata_o == $past(result[13:6]))
    else $error("twos complement format wrong");

  // control register reads back its fields, reserved positions zero
  chk_ctrl_readback: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.sample && sel_ctrl) |=> (rdata_o[7:6] == 2'h0) && (rdata_o[4] == 1'b0) &&
    (rdata_o[5] == $past(output_format_select_o)) &&
    (rdata_o[3:0] == {$past(readback_mode_field_o), $past(clock_divide_field_o)}))
    else $error("control register read back wrong");

  // addresses outside the map read as zero
  chk_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (req_i.sample && !(sel_low || sel_high || sel_lim || sel_ctrl)) |=> rdata_o == 8'h00)
    else $error("unmapped address read not zero");

  // write to the control register lands in the fields
  chk_ctrl_write: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ctrl_wr |=> (readback_mode_field_o == $past(req_i.wdata[3:2])) &&
    (clock_divide_field_o == $past(req_i.wdata[1:0])) &&
    (output_format_select_o == $past(req_i.wdata[5])))
    else $error("control write lost");

  // divide by eight gives seven quiet cycles after a pulse
  // a pulse sampled on the write edge still belongs to the old code, so none starts there
  chk_divide_eight: assert property (@(posedge core_clk_i) disable iff (!nrst_i || ctrl_wr)
    (divided_conversion_clock_en_o && clock_divide_field_o == 2'h3 && !ctrl_wr) |=>
    !divided_conversion_clock_en_o [*7] ##1 divided_conversion_clock_en_o)
    else $error("divide by eight period wrong");

  // divide by one pulses on every cycle
  chk_divide_one: assert property (@(posedge core_clk_i) disable iff (!nrst_i || ctrl_wr)
    (divided_conversion_clock_en_o && clock_divide_field_o == 2'h0 && !ctrl_wr) |=>
    divided_conversion_clock_en_o)
    else $error("divide by one period wrong");

  // divide by two gives one quiet cycle after a pulse
  chk_divide_two: assert property (@(posedge core_clk_i) disable iff (!nrst_i || ctrl_wr)
    (divided_conversion_clock_en_o && clock_divide_field_o == 2'h1 && !ctrl_wr) |=>
    !divided_conversion_clock_en_o ##1 divided_conversion_clock_en_o)
    else $error("divide by two period wrong");

  // divide by four gives three quiet cycles after a pulse
  chk_divide_four: assert property (@(posedge core_clk_i) disable iff (!nrst_i || ctrl_wr)
    (divided_conversion_clock_en_o && clock_divide_field_o == 2'h2 && !ctrl_wr) |=>
    !divided_conversion_clock_en_o [*3] ##1 divided_conversion_clock_en_o)
    else $error("divide by four period wrong");

  // registers are clear right after reset
  chk_reset_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> (ctrl == adcr_ctrl_t'(0)) && (result == `ADCR_RES_RESET) &&
    (rdata_o == `ADCR_BYTE_ZERO))
    else $error("register not clear after reset");

  // main scenarios
  cov_binary_read: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    req_i.sample && sel_high && ctrl.output_format_select);
  cov_lsb_first_read: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    req_i.sample && lsb_first_i);
  cov_overrange_set: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    conv_done_i && (|lim_sync));
  cov_divide_eight: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    divided_conversion_clock_en_o && ctrl.cfd == 2'b11);
  cov_unmapped_read: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    req_i.sample && !(sel_low || sel_high || sel_lim || sel_ctrl));

endmodule

// [adcr_regs.svh]
// register map, field positions and timing figures of the converter register block
`ifndef ADCR_REGS_SVH
`define ADCR_REGS_SVH

// register address width and addresses
`define ADCR_ADDR_W 5
`define ADCR_ADDR_RES_LOW 5'h00
`define ADCR_ADDR_RES_HIGH 5'h01
`define ADCR_ADDR_LIMITS 5'h02
`define ADCR_ADDR_CTRL 5'h03

// data widths
`define ADCR_DATA_W 8
`define ADCR_RES_W 14
`define ADCR_LIM_W 6

// result split between the low and high register
`define ADCR_RES_LOW_TOP 5
`define ADCR_RES_HIGH_BOT 6

// converter control field positions
`define ADCR_CTRL_BIN_BIT 5
`define ADCR_CTRL_RBM_HI 3
`define ADCR_CTRL_RBM_LO 2
`define ADCR_CTRL_CFD_HI 1
`define ADCR_CTRL_CFD_LO 0

// reset values
`define ADCR_CTRL_RESET 8'h00
`define ADCR_BYTE_ZERO 8'h00
`define ADCR_RES_RESET 14'h0000
`define ADCR_LIM_RESET 6'h00

// conversion clock divider
`define ADCR_DIV_CNT_W 3
`define ADCR_DIV_CNT_ZERO 3'h0
`define ADCR_DIV_CNT_ONE 3'h1

// clock rates in hertz
`define ADCR_CONVERTER_INPUT_CLOCK_HZ 10000000
`define ADCR_DIVIDED_CONVERSION_CLOCK_MAX_HZ 2500000

`endif

// [testbench.sv]
// self-checking bench for the converter register block
`timescale 1ns/1ns
module testbench;
  import adcr_pkg::*;
  logic core_clk_i = 1'b0; // 10 MHz clock
  logic nrst_i = 1'b0; // reset, active low
  adcr_req_t req = '0; // register request
  logic lsb_first = 1'b0; // serial bit order
  logic shift = 1'b0; // serial advance pulse
  logic go = 1'b0; // start of a model conversion
  logic [13:0] val = '0; // result to convert
  logic [5:0] flg = '0; // comparator levels
  logic conv_done;
  logic [13:0] conv_result;
  logic [5:0] limit_raw;
  logic [7:0] rdata;
  logic sdo, fmt, den, dlim;
  logic [1:0] rbm, cfd;
  int failures = 0;
  int comparisons = 0;
  always #50 core_clk_i = ~core_clk_i;
  adcr_core_model core (.core_clk_i(core_clk_i), .go_i(go), .value_i(val), .flags_i(flg),
    .conv_done_o(conv_done), .conv_result_o(conv_result), .limit_raw_o(limit_raw));
  adcr_regs uut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .req_i(req),
    .lsb_first_i(lsb_first), .shift_i(shift), .conv_done_i(conv_done),
    .conv_result_i(conv_result), .limit_raw_i(limit_raw), .rdata_o(rdata), .sdo_o(sdo),
    .output_format_select_o(fmt), .readback_mode_field_o(rbm), .clock_divide_field_o(cfd),
    .divided_conversion_clock_en_o(den), .divided_conversion_clock_over_limit_o(dlim));
  // one comparison, counted
  task cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // single byte write, reserved control bits kept zero by the callers
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge core_clk_i);
    req.wr <= 1'b0;
    #1;
  endtask
  // sample a register and compare the byte a cycle later
  task rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    req.sample <= 1'b1;
    req.addr <= a;
    @(posedge core_clk_i);
    req.sample <= 1'b0;
    #1;
    cmp("rdata", exp, rdata);
  endtask
  // walk the serial bits of the byte just sampled
  task ser_chk(input logic [7:0] exp);
    for (int k = 0; k < 8; k++)
    begin
      cmp("sdo", {7'h0, lsb_first ? exp[k] : exp[7-k]}, {7'h0, sdo});
      @(posedge core_clk_i);
      shift <= 1'b1;
      @(posedge core_clk_i);
      shift <= 1'b0;
      #1;
    end
  endtask
  // run one conversion through the core model
  task conv(input logic [13:0] v, input logic [5:0] f);
    @(posedge core_clk_i);
    go <= 1'b1;
    val <= v;
    flg <= f;
    @(posedge core_clk_i);
    go <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask
  // set mode and divide code, count enable pulses over 16 cycles
  task div_chk(input logic [1:0] c);
    int n;
    n = 0;
    wr(5'h03, {4'h0, c, c});
    cmp("rbm", {6'h0, c}, {6'h0, rbm});
    repeat (10) @(posedge core_clk_i);
    repeat (16)
    begin
      @(posedge core_clk_i);
      #1;
      n += den;
    end
    cmp("divided_conversion_clock_pulses", 8'(16 >> c), 8'(n));
    cmp("divided_conversion_clock_limit", {7'h0, c < 2'h2}, {7'h0, dlim});
  endtask
  // verdict and end of run
  task stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog far beyond the few hundred cycles of the tests
  initial
  begin
    #2000000;
    failures++;
    stop_test();
  end
  // test sequence
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    cmp("fields", 8'h00, {3'h0, fmt, rbm, cfd});
    rd_chk(5'h03, 8'h00);
    rd_chk(5'h00, 8'h00);
    rd_chk(5'h02, 8'h00);
    wr(5'h03, 8'h2f);
    cmp("fields", 8'h1f, {3'h0, fmt, rbm, cfd});
    rd_chk(5'h03, 8'h2f);
    for (int i = 0; i < 4; i++)
      div_chk(2'(i));
    conv(14'h2a5c, 6'h15);
    rd_chk(5'h02, 8'h15);
    rd_chk(5'h00, 8'h71);
    rd_chk(5'h01, 8'ha9);
    ser_chk(8'ha9);
    for (int a = 0; a < 3; a++)
      wr(5'(a), 8'hff);
    @(posedge core_clk_i);
    lsb_first <= 1'b1;
    rd_chk(5'h00, 8'h71);
    ser_chk(8'h71);
    rd_chk(5'h01, 8'ha9);
    conv(14'h0123, 6'h00);
    rd_chk(5'h00, 8'h8c);
    rd_chk(5'h02, 8'h00);
    wr(5'h03, 8'h20);
    rd_chk(5'h01, 8'h84);
    conv(14'h3fff, 6'h3f);
    cmp("rdata_hold", 8'h84, rdata);
    rd_chk(5'h1f, 8'h00);
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    cmp("fields", 8'h00, {3'h0, fmt, rbm, cfd});
    rd_chk(5'h01, 8'h00);
    stop_test();
  end
endmodule
